// [design/tcp_timer.sv]
// Purpose: 8-bit timer/counter with shared prescaler, apb slave
// Assumes: pclk is the instruction-cycle clock, 25 MHz
// Notes: count pin is asynchronous and synchronised here
//
// Operation
// - eight-bit count register, readable and writable
// - source select zero gives timer mode
// - timer mode counts every instruction cycle when the assign bit is one
// - write inhibits counting for two cycles
// - source select one counts pin events
// - counter mode counts one chosen pin edge
// - edge select zero rising, one falling
// - prescaler serves exactly one user
// - assign bit zero gives prescaler to timer
// - prescaler count hidden from software
// - prescale ratios 1:2 through 1:256
`timescale 1ns/10ps
`include "tcp_consts.svh"

module tcp_timer (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external count pin
    input wire logic external_count_pin,
    // watchdog side of the shared prescaler
    input wire logic watchdog_tick,
    output logic watchdog_tick_scaled
);

    // =====================================================
    // declarations
    logic [7:0] timer_count_reg;
    logic [7:0] timer_count_next;
    logic [5:0] option_reg;
    tcp_pkg::tcp_inh_state_t inh_reg;
    tcp_pkg::tcp_inh_state_t inh_next;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic pin_prev_reg;
    logic assign_prev_reg;
    logic [31:0] prdata_reg;

    // =====================================================
    // apb decode
    wire apb_access = psel && penable;
    wire apb_wr = apb_access && pwrite;
    wire hit_count = (paddr == `TCP_OFF_COUNT);
    wire hit_option = (paddr == `TCP_OFF_OPTION);
    wire hit_status = (paddr == `TCP_OFF_STATUS);
    wire hit_any = hit_count || hit_option || hit_status;
    wire wr_count = apb_wr && hit_count && pstrb[0];
    wire wr_option = apb_wr && hit_option && pstrb[0];

    // zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = apb_access && !hit_any;
    assign prdata = prdata_reg;

    // =====================================================
    // option fields
    wire src_pin = option_reg[`TCP_OPT_SOURCE];
    wire edge_fall = option_reg[`TCP_OPT_EDGE];
    wire ps_to_wdt = option_reg[`TCP_OPT_ASSIGN];
    wire [2:0] ps_rate = option_reg[`TCP_OPT_PS_MSB:`TCP_OPT_PS_LSB];

    // =====================================================
    // count events
    wire pin_rise = pin_sync_reg && !pin_prev_reg;
    wire pin_fall = !pin_sync_reg && pin_prev_reg;
    wire pin_event = edge_fall ? pin_fall : pin_rise;
    // timer mode ticks every cycle, counter mode on pin edges
    wire raw_event = src_pin ? pin_event : 1'b1;

    // =====================================================
    // prescaler routing: one user at a time
    wire ps_in = ps_to_wdt ? watchdog_tick : raw_event;
    wire ps_out;
    // clear on reassignment; the new user still sees the stale phase for one cycle
    wire ps_clear = (ps_to_wdt != assign_prev_reg) || wr_count;

    // hidden prescale count, no bus path to it
    tcp_prescaler #(
        .WIDTH(`TCP_PS_WIDTH)
    ) u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .clear(ps_clear),
        .tick_in(ps_in),
        .rate_sel(ps_rate),
        .tick_out(ps_out)
    );

    // divided when assigned here, undivided otherwise
    wire count_event = ps_to_wdt ? raw_event : ps_out;
    assign watchdog_tick_scaled = ps_to_wdt ? ps_out : watchdog_tick;

    // =====================================================
    // write-inhibit sequencer
    wire inhibit = (inh_reg != tcp_pkg::TCP_RUN);

    always_comb begin
        case (inh_reg)
            tcp_pkg::TCP_RUN: begin
                inh_next = tcp_pkg::TCP_RUN;
            end
            tcp_pkg::TCP_HOLD1: begin
                inh_next = tcp_pkg::TCP_HOLD2;
            end
            tcp_pkg::TCP_HOLD2: begin
                inh_next = tcp_pkg::TCP_RUN;
            end
            default: begin
                inh_next = tcp_pkg::TCP_RUN;
            end
        endcase
        if (wr_count) begin
            inh_next = tcp_pkg::TCP_HOLD1;
        end
    end

    // =====================================================
    // count next value; natural 8-bit wrap
    always_comb begin
        timer_count_next = timer_count_reg;
        if (wr_count) begin
            timer_count_next = pwdata[7:0];
        end else if (count_event && !inhibit) begin
            timer_count_next = timer_count_reg + 8'h01;
        end
    end

    // =====================================================
    // pin synchroniser and edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= external_count_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // =====================================================
    // count, option and inhibit state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count_reg <= `TCP_COUNT_RESET;
            option_reg <= `TCP_OPT_RESET;
            inh_reg <= tcp_pkg::TCP_RUN;
            assign_prev_reg <= 1'b1;
        end else begin
            timer_count_reg <= timer_count_next;
            inh_reg <= inh_next;
            assign_prev_reg <= ps_to_wdt;
            if (wr_option) begin
                option_reg <= pwdata[`TCP_OPT_WIDTH-1:0];
            end
        end
    end

    // =====================================================
    // read data register, loaded in the setup cycle
    wire [31:0] rd_mux =
        hit_count ? {24'h000000, timer_count_reg} :
        hit_option ? {26'h0000000, option_reg} :
        hit_status ? {31'h00000000, inhibit} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= rd_mux; // sampled in setup, shown in access
        end
    end

endmodule

// [design/tcp_consts.svh]
// Purpose: shared constants for the prescaled timer/counter
// Assumes: included by bare name; definitions only
// Notes: apb word offsets and option field positions
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH

// =====================================================
// register map (byte addresses)
`define TCP_OFF_COUNT 12'h000
`define TCP_OFF_OPTION 12'h004
`define TCP_OFF_STATUS 12'h008

// =====================================================
// option register fields and reset
`define TCP_OPT_PS_LSB 0
`define TCP_OPT_PS_MSB 2
`define TCP_OPT_ASSIGN 3
`define TCP_OPT_EDGE 4
`define TCP_OPT_SOURCE 5
`define TCP_OPT_WIDTH 6
`define TCP_OPT_RESET 6'h3f

// =====================================================
// timing and counts
`define TCP_COUNT_RESET 8'h00
`define TCP_INHIBIT_CYCLES 2'h2
`define TCP_PS_WIDTH 8

`endif

// [design/tcp_pkg.sv]
// Purpose: types for the prescaled timer/counter
// Assumes: nothing
// Notes: states are one-hot
package tcp_pkg;

    // =====================================================
    // write-inhibit sequencer states
    typedef enum logic [2:0] {
        TCP_RUN = 3'h1,
        TCP_HOLD1 = 3'h2,
        TCP_HOLD2 = 3'h4
    } tcp_inh_state_t;

endpackage

// [design/tcp_prescaler.sv]
// Purpose: free running prescale counter with tap select
// Assumes: tick_in is a one-cycle enable from the same clock
// Notes: count is never visible to software
`timescale 1ns/10ps
`include "tcp_consts.svh"

module tcp_prescaler #(
    parameter int WIDTH = `TCP_PS_WIDTH
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic clear,
    input wire logic tick_in,
    input wire logic [2:0] rate_sel,
    // result
    output logic tick_out
);

    logic [WIDTH-1:0] ps_reg;
    logic [WIDTH-1:0] ps_next;
    logic [WIDTH-1:0] tap_mask;

    // ratio 2^(rate_sel+1): all low bits must be ones before wrap
    assign tap_mask = WIDTH'((9'h002 << rate_sel) - 9'h001);
    assign ps_next = ps_reg + WIDTH'(1);
    assign tick_out = tick_in && ((ps_reg & tap_mask) == tap_mask);

    // hidden counter, cleared when the assignment changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps_reg <= '0;
        end else if (clear) begin
            ps_reg <= '0;
        end else if (tick_in) begin
            ps_reg <= ps_next;
        end
    end

endmodule

// [bench/tcp_pin_model.sv]
// Purpose: source on the count pin
// Assumes: pin idles low
// Notes: edges land on a rising clock edge, by non-blocking assignment
`timescale 1ns/10ps
module tcp_pin_model (
    // count pin
    output logic pin
);
    initial pin = 1'b0;
    // called right after a rising edge; the design still syncs it
    task automatic drive(input logic v);
        pin <= v;
    endtask
endmodule

// [bench/tcp_timer_chk.sv]
// Purpose: port checks for tcp_timer
// Assumes: bound to tcp_timer
// Notes: shadows the assign bit
`timescale 1ns/10ps
`include "tcp_consts.svh"
module tcp_timer_chk (
    // clock, reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // watchdog
    input wire logic watchdog_tick,
    input wire logic watchdog_tick_scaled
);
    logic acc;
    logic asg_reg;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // =====================================
    // assign bit shadow
    assign acc = psel && penable;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            asg_reg <= 1'b1;
        else if (acc && pwrite && pstrb[0] && paddr == 12'h004)
            asg_reg <= pwdata[3];
    end
    a_ready_high: assert property (pready) else $error("ready low");
    a_err_map: assert property (acc |-> pslverr == !(paddr ==
        `TCP_OFF_COUNT || paddr == `TCP_OFF_OPTION ||
        paddr == `TCP_OFF_STATUS)) else $error("bad error");
    a_count_byte: assert property (acc && paddr == 12'h0 |->
        prdata[31:8] == 24'h0) else $error("count wide");
    a_opt_bits: assert property (acc && paddr == 12'h004 |->
        prdata[31:6] == 26'h0) else $error("option wide");
    a_rd_hold: assert property (!$past(psel && !penable && !pwrite) |->
        $stable(prdata)) else $error("read data moved");
    a_wd_direct: assert property (!asg_reg |->
        watchdog_tick_scaled == watchdog_tick) else $error("wd path");
    a_wd_gated: assert property (asg_reg && !watchdog_tick |->
        !watchdog_tick_scaled) else $error("wd spurious");
    a_err_idle: assert property (!acc |-> !pslverr) else $error("err idle");
endmodule
bind tcp_timer tcp_timer_chk i_tcp_timer_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .watchdog_tick, .watchdog_tick_scaled);

// [bench/tcp_timer_tb.sv]
// Purpose: bench for tcp_timer
// Assumes: pin model on the count pin
// Notes: none
`timescale 1ns/10ps
`include "tcp_consts.svh"
module tcp_timer_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, watchdog_tick = 1'b0, pin, pready, pslverr, err;
    logic watchdog_tick_scaled;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] base;
    int fails = 0, checks_done = 0;
    tcp_timer i_tcp_timer (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
        .external_count_pin(pin), .watchdog_tick, .watchdog_tick_scaled);
    tcp_pin_model i_tcp_pin_model (.pin);
    // clock, and a watchdog pulse every other cycle
    always #20 pclk = ~pclk;
    always @(posedge pclk) watchdog_tick <= ~watchdog_tick;
    task automatic check(input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // request held until pready is sampled high
    task automatic xfer(input logic w, logic [11:0] a, logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
    endtask
    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // hang guard, runs are near 2200 cycles
    initial begin
        #400000;
        fails++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(0, `TCP_OFF_COUNT, 0);
        check(rd, 32'h0);
        xfer(0, `TCP_OFF_OPTION, 0);
        check(rd, 32'h3f);
        check({31'h0, err}, 32'h0);
        xfer(1, 12'h00c, 32'hff);
        check({31'h0, err}, 32'h1);
        // undivided timer: write, then back-to-back reads
        xfer(1, `TCP_OFF_OPTION, 32'h08);
        xfer(1, `TCP_OFF_COUNT, 32'hfe);
        xfer(0, `TCP_OFF_COUNT, 0);
        check(rd, 32'hfe);
        xfer(0, `TCP_OFF_COUNT, 0);
        check(rd, 32'hfe);
        xfer(0, `TCP_OFF_COUNT, 0);
        check(rd, 32'h0);
        // status reads 1 in the first cycle after the write and 0 in the third
        xfer(1, `TCP_OFF_COUNT, 32'h10);
        xfer(0, `TCP_OFF_STATUS, 0);
        check(rd, 32'h1);
        xfer(0, `TCP_OFF_STATUS, 0);
        check(rd, 32'h0);
        // reads 4 ratios apart differ by 4
        for (int r = 0; r < 8; r++) begin
            xfer(1, `TCP_OFF_OPTION, {29'h0, r[2:0]});
            // reassignment clears the prescaler; keep it out of the window
            idle(1);
            xfer(0, `TCP_OFF_COUNT, 0);
            base = rd[7:0] + 8'h4;
            idle((4 << (r + 1)) - 2);
            xfer(0, `TCP_OFF_COUNT, 0);
            check(rd, {24'h0, base});
        end
        // pin edges, both polarities
        for (int e = 0; e < 2; e++) begin
            xfer(1, `TCP_OFF_OPTION, 32'h28 | {27'h0, e[0], 4'h0});
            xfer(0, `TCP_OFF_COUNT, 0);
            base = rd[7:0];
            for (int v = 1; v >= 0; v--) begin
                idle(2);
                i_tcp_pin_model.drive(v[0]);
                idle(8);
                xfer(0, `TCP_OFF_COUNT, 0);
                base = base + {7'h0, v != e};
                check(rd, {24'h0, base});
            end
        end
        idle(2);
        close_out();
    end
endmodule
